//--- bench/crcen_master.sv
// wishbone classic master standing in for the processor or dma channel
`timescale 1ns/1ps
`default_nettype none

module crcen_master
    import crcen_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             wb_ack_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic                  wb_cyc_o,
    output logic                  wb_stb_o,
    output logic                  wb_we_o,
    output logic      [ADR_W-1:0] wb_adr_o,
    output logic      [3:0]       wb_sel_o,
    output logic      [31:0]      wb_dat_o
);
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o  = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0;
    end

    // one cycle, held until ack, then one idle cycle; callers chain these back to back
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                        input logic [31:0] dat, output logic [31:0] rd, output int lat);
        lat = 0;
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= we;
        wb_adr_o <= adr;
        wb_sel_o <= sel;
        wb_dat_o <= dat;
        do begin
            @(posedge clk_i);
            lat++;
        end while (wb_ack_i !== 1'b1 && lat < 50);
        rd = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        // released data lines show a changed value
        wb_dat_o <= ~dat;
        @(posedge clk_i);
    endtask
endmodule // crcen_master
`default_nettype wire

//--- bench/crcen_top_tb.sv
// self-checking testbench of the crc engine
`timescale 1ns/1ps
`default_nettype none

module crcen_top_tb
    import crcen_pkg::*;
();
    localparam logic [3:0]  SELS [7] = '{SEL_B0, SEL_B1, SEL_B2, SEL_B3, SEL_LO, SEL_HI, SEL_WORD};
    localparam logic [7:0]  RA [6] = '{OFF_MODE, OFF_SEED, OFF_POLY, OFF_DATA, OFF_SUM, 8'h14};
    localparam logic [31:0] RV [6] = '{32'h0, 32'h0000_ffff, 32'h04c1_1db7, 32'h0, 32'h0000_ffff, 32'h0};
    localparam logic [3:0]  TSEL [3] = '{SEL_B0, SEL_LO, SEL_WORD};
    localparam int          TLEN [3] = '{2, 2, 4};

    logic             clk_i;
    logic             rst_i;
    logic             wb_cyc;
    logic             wb_stb;
    logic             wb_we;
    logic [ADR_W-1:0] wb_adr;
    logic [3:0]       wb_sel;
    logic [31:0]      wb_wdat;
    logic [31:0]      wb_rdat;
    logic             wb_ack;
    crcen_mode_t      cur_m;
    logic [31:0]      cur_p;
    logic [31:0]      cur_c;
    logic [31:0]      rdat;
    logic [31:0]      exp_p;
    int               lat;
    int               bad_count;
    int               tests_run;

    crcen_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
                   .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
                   .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
    crcen_master u_mst (.clk_i(clk_i), .wb_ack_i(wb_ack), .wb_dat_i(wb_rdat), .wb_cyc_o(wb_cyc),
                        .wb_stb_o(wb_stb), .wb_we_o(wb_we), .wb_adr_o(wb_adr),
                        .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic we, input logic [7:0] a, input logic [3:0] s,
                       input logic [31:0] d);
        u_mst.xfer(we, a, s, d, rdat, lat);
        if (lat >= 50) begin
            bad_count++;
            $display("mismatch ack_wait expected ack seen none");
            stop_test();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic w16(input crcen_mode_t m);
        return m.psel == PSEL_CCITT || m.psel == PSEL_CRC16;
    endfunction

    function automatic logic [31:0] poly_of(input crcen_mode_t m);
        case (m.psel)
            PSEL_CCITT: return 32'h0000_1021;
            PSEL_CRC16: return 32'h0000_8005;
            PSEL_CRC32: return 32'h04c1_1db7;
            default:    return cur_p;
        endcase
    endfunction

    // msb-first shift of one byte into the running value
    function automatic logic [31:0] fold(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] p;
        p = poly_of(cur_m);
        if (cur_m.rev_in) b = {<<{b}};
        if (cur_m.cmpl_in) b = ~b;
        if (w16(cur_m)) begin
            c[15:8] = c[15:8] ^ b;
            for (int i = 0; i < 8; i++) begin
                c[15:0] = {c[14:0], 1'b0} ^ (c[15] ? p[15:0] : 16'h0);
            end
            c[31:16] = 16'h0;
        end else begin
            c[31:24] = c[31:24] ^ b;
            for (int i = 0; i < 8; i++) begin
                c = {c[30:0], 1'b0} ^ (c[31] ? p : 32'h0);
            end
        end
        return c;
    endfunction

    function automatic logic [31:0] sum_out(input logic [31:0] c);
        logic [31:0] r;
        r = c;
        if (cur_m.rev_sum) r = w16(cur_m) ? {16'h0, {<<{c[15:0]}}} : {<<{c}};
        if (cur_m.cmpl_sum) r = w16(cur_m) ? {16'h0, ~r[15:0]} : ~r;
        return r;
    endfunction

    task automatic put(input logic [3:0] s, input logic [31:0] d);
        bus(1'b1, OFF_DATA, s, d);
        for (int i = 0; i < 4; i++) begin
            if (s[i]) cur_c = fold(cur_c, d[8*i+:8]);
        end
    endtask

    task automatic set_seed(input logic [31:0] s);
        bus(1'b1, OFF_SEED, 4'hf, s);
        cur_c = w16(cur_m) ? {16'h0, s[15:0]} : s;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_i = 1'b1;
        bad_count = 0;
        tests_run = 0;
        void'($urandom(42018));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, RA[i], 4'hf, 32'h0);
            check("reset_value", RV[i], rdat);
            check("read_wait", 32'd2, lat);
        end
        $display("test reset_values done");
        for (int ps = 0; ps < 4; ps++) begin
            for (int r = 0; r < 3; r++) begin
                cur_m.psel = crcen_psel_t'(ps[1:0]);
                {cur_m.cmpl_sum, cur_m.rev_sum, cur_m.cmpl_in, cur_m.rev_in} =
                    (r == 0) ? 4'hf : (r == 1) ? 4'h0 : 4'($urandom);
                bus(1'b1, OFF_MODE, 4'hf, {26'h0, cur_m});
                bus(1'b0, OFF_MODE, 4'hf, 32'h0);
                check("mode", {26'h0, cur_m}, rdat);
                cur_p = $urandom;
                bus(1'b1, OFF_POLY, 4'hf, cur_p);
                bus(1'b0, OFF_POLY, 4'hf, 32'h0);
                check("poly", cur_p, rdat);
                set_seed((r == 0) ? 32'hffff_ffff : $urandom);
                repeat (6) put(SELS[$urandom_range(0, 6)], $urandom);
                bus(1'b0, OFF_SUM, 4'hf, 32'h0);
                check("sum", sum_out(cur_c), rdat);
            end
        end
        $display("test checksum_modes done");
        // zero seed and one byte 01 leave exactly the generator terms, read back complemented from the sum
        for (int ps = 0; ps < 4; ps++) begin
            cur_m = '{1'b1, 1'b0, 1'b0, 1'b0, crcen_psel_t'(ps[1:0])};
            bus(1'b1, OFF_MODE, 4'hf, {26'h0, cur_m});
            set_seed(32'h0);
            put(SEL_B0, 32'h0000_0001);
            bus(1'b0, OFF_SUM, 4'hf, 32'h0);
            exp_p = poly_of(cur_m);
            exp_p = w16(cur_m) ? {16'h0, ~exp_p[15:0]} : ~exp_p;
            check("single_term", exp_p, rdat);
        end
        $display("test single_term done");
        for (int k = 0; k < 3; k++) begin
            set_seed($urandom);
            put(TSEL[k], $urandom);
            bus(1'b0, OFF_SUM, 4'hf, 32'h0);
            check("sum_after_write", sum_out(cur_c), rdat);
            check("hold_off_wait", TLEN[k], lat);
        end
        $display("test step_timing done");
        bus(1'b1, OFF_DATA, 4'h5, $urandom);
        bus(1'b1, OFF_SUM, 4'hf, $urandom);
        bus(1'b1, 8'h14, 4'hf, $urandom);
        bus(1'b0, OFF_SUM, 4'hf, 32'h0);
        check("sum_unchanged", sum_out(cur_c), rdat);
        bus(1'b0, OFF_DATA, 4'hf, 32'h0);
        check("data_read", 32'h0, rdat);
        bus(1'b0, 8'h0d, 4'hf, 32'h0);
        check("unmapped_read", 32'h0, rdat);
        $display("test refusals done");
        stop_test();
    end
endmodule // crcen_top_tb
`default_nettype wire

//--- logic/crcen_top.sv
// crc engine: wishbone classic slave with byte-serial checksum datapath
//
// How it works
// - the mode register selects one of ccitt, crc-16, crc-32 or a software-programmed generator polynomial.
// - the ccitt setting uses the 16-bit polynomial x16+x12+x5+1.
// - the crc-16 setting uses the 16-bit polynomial x16+x15+x2+1.
// - the crc-32 setting uses the standard 32-bit ethernet-style polynomial 04c11db7.
// - input bytes may be bit-reversed and one's-complemented, each by its own mode bit.
// - the checksum read back may be bit-reversed and complemented by two further mode bits.
// - data writes may follow back to back from cpu or dma with no handshake in software.
// - byte enables of a data write give its size: byte, halfword or word.
// - a byte write is folded into the checksum in one clock cycle.
// - a halfword write takes two byte steps on two successive cycles.
// - a word write takes four byte steps on four successive cycles.
// - a fourth polynomial setting uses a 32-bit polynomial programmed by software.
//
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module crcen_top
    import crcen_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [7:0] rev8(input logic [7:0] b);
        logic [7:0] r;
        integer     i;
        r = 8'h00;
        for (i = 0; i < 8; i++) begin
            r[i] = b[7-i];
        end
        return r;
    endfunction

    function automatic logic [31:0] rev32(input logic [31:0] b);
        logic [31:0] r;
        integer      i;
        r = 32'h0;
        for (i = 0; i < 32; i++) begin
            r[i] = b[31-i];
        end
        return r;
    endfunction

    // one byte into the remainder, msb first; 16-bit forms live in the low half
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b,
                                             input logic [31:0] p, input logic w16);
        logic [31:0] r;
        logic        fb;
        integer      i;
        r = c;
        for (i = 7; i >= 0; i--) begin
            fb = (w16 ? r[15] : r[31]) ^ b[i];
            r  = {r[30:0], 1'b0};
            if (fb) begin
                r = r ^ p;
            end
        end
        if (w16) begin
            r = {16'h0, r[15:0]};
        end
        return r;
    endfunction

    function automatic logic [31:0] sum_view(input logic [31:0] c, input crcen_mode_t m,
                                             input logic w16);
        logic [31:0] r;
        logic [31:0] t;
        r = c;
        t = rev32(c);
        if (m.rev_sum) begin
            r = w16 ? {16'h0, t[31:16]} : t;
        end
        if (m.cmpl_sum) begin
            r = w16 ? {16'h0, ~r[15:0]} : ~r;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state

    crcen_state_t st_reg,   st_next;
    crcen_mode_t  mode_reg, mode_next;
    logic [31:0]  seed_reg, seed_next;
    logic [31:0]  poly_reg, poly_next;
    logic [31:0]  crc_reg,  crc_next;
    logic [31:0]  sh_reg,   sh_next;
    logic [2:0]   cnt_reg,  cnt_next;
    logic [31:0]  dat_reg,  dat_next;
    logic         ack_reg,  ack_next;

    logic         acc;
    logic         w16;
    logic [31:0]  poly_eff;
    logic [7:0]   in_byte;
    logic [2:0]   acc_len;
    logic [31:0]  acc_data;

    // a new access is only taken when no byte steps are pending
    assign acc = wb_cyc_i & wb_stb_i & ~ack_reg & (st_reg == ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////////
    // polynomial and byte shaping

    always_comb begin
        poly_eff = POLY_CRC32;
        w16      = 1'b0;
        case (mode_reg.psel)
            PSEL_CCITT: begin
                poly_eff = POLY_CCITT;
                w16      = 1'b1;
            end
            PSEL_CRC16: begin
                poly_eff = POLY_CRC16;
                w16      = 1'b1;
            end
            PSEL_CRC32: begin
                poly_eff = POLY_CRC32;
            end
            default: begin
                poly_eff = poly_reg;
            end
        endcase
    end

    always_comb begin
        in_byte = sh_reg[7:0];
        if (mode_reg.rev_in) begin
            in_byte = rev8(in_byte);
        end
        if (mode_reg.cmpl_in) begin
            in_byte = ~in_byte;
        end
    end

    // size of a data write from its byte enables; zero means ignored
    always_comb begin
        acc_len  = 3'h0;
        acc_data = 32'h0;
        if (wb_sel_i == SEL_WORD) begin
            acc_len  = LEN_WORD;
            acc_data = wb_dat_i;
        end else if (wb_sel_i == SEL_LO) begin
            acc_len  = LEN_HALF;
            acc_data = {16'h0, wb_dat_i[15:0]};
        end else if (wb_sel_i == SEL_HI) begin
            acc_len  = LEN_HALF;
            acc_data = {16'h0, wb_dat_i[31:16]};
        end else if (wb_sel_i == SEL_B0) begin
            acc_len  = LEN_BYTE;
            acc_data = {24'h0, wb_dat_i[7:0]};
        end else if (wb_sel_i == SEL_B1) begin
            acc_len  = LEN_BYTE;
            acc_data = {24'h0, wb_dat_i[15:8]};
        end else if (wb_sel_i == SEL_B2) begin
            acc_len  = LEN_BYTE;
            acc_data = {24'h0, wb_dat_i[23:16]};
        end else if (wb_sel_i == SEL_B3) begin
            acc_len  = LEN_BYTE;
            acc_data = {24'h0, wb_dat_i[31:24]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus slave and byte-step sequencer

    always_comb begin
        st_next   = st_reg;
        mode_next = mode_reg;
        seed_next = seed_reg;
        poly_next = poly_reg;
        crc_next  = crc_reg;
        sh_next   = sh_reg;
        cnt_next  = cnt_reg;
        dat_next  = dat_reg;
        ack_next  = 1'b0;
        case (st_reg)
            ST_RUN: begin
                crc_next = crc_step(crc_reg, in_byte, poly_eff, w16);
                sh_next  = {8'h00, sh_reg[31:8]};
                cnt_next = cnt_reg - 3'h1;
                if (cnt_reg == 3'h1) begin
                    st_next = ST_IDLE;
                end
            end
            default: begin
                if (acc) begin
                    ack_next = 1'b1;
                    dat_next = 32'h0;
                    if (wb_we_i) begin
                        if (wb_adr_i == OFF_MODE) begin
                            mode_next = crcen_mode_t'(wb_dat_i[5:0]);
                        end else if (wb_adr_i == OFF_SEED) begin
                            seed_next = wb_dat_i;
                            crc_next  = w16 ? {16'h0, wb_dat_i[15:0]} : wb_dat_i;
                        end else if (wb_adr_i == OFF_POLY) begin
                            poly_next = wb_dat_i;
                        end else if (wb_adr_i == OFF_DATA && acc_len != 3'h0) begin
                            sh_next  = acc_data;
                            cnt_next = acc_len;
                            st_next  = ST_RUN;
                        end
                    end else begin
                        if (wb_adr_i == OFF_MODE) begin
                            dat_next = {26'h0, mode_reg};
                        end else if (wb_adr_i == OFF_SEED) begin
                            dat_next = seed_reg;
                        end else if (wb_adr_i == OFF_POLY) begin
                            dat_next = poly_reg;
                        end else if (wb_adr_i == OFF_SUM) begin
                            dat_next = sum_view(crc_reg, mode_reg, w16);
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg   <= ST_IDLE;
            mode_reg <= MODE_RST;
            seed_reg <= SEED_RST;
            poly_reg <= POLY_RST;
            crc_reg  <= SEED_RST;
            sh_reg   <= 32'h0;
            cnt_reg  <= 3'h0;
            dat_reg  <= 32'h0;
            ack_reg  <= 1'b0;
        end else begin
            st_reg   <= st_next;
            mode_reg <= mode_next;
            seed_reg <= seed_next;
            poly_reg <= poly_next;
            crc_reg  <= crc_next;
            sh_reg   <= sh_next;
            cnt_reg  <= cnt_next;
            dat_reg  <= dat_next;
            ack_reg  <= ack_next;
        end
    end

    assign wb_dat_o = dat_reg;
    assign wb_ack_o = ack_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    logic data_acc;
    assign data_acc = acc & wb_we_i & (wb_adr_i == OFF_DATA);

    sequence s_run1;
        st_reg == ST_RUN ##1 st_reg == ST_IDLE;
    endsequence

    sequence s_run2;
        st_reg == ST_RUN [*2] ##1 st_reg == ST_IDLE;
    endsequence

    sequence s_run4;
        st_reg == ST_RUN [*4] ##1 st_reg == ST_IDLE;
    endsequence

    a_byte_one_step: assert property (@(posedge clk_i) disable iff (rst_i)
        data_acc && acc_len == LEN_BYTE |=> s_run1)
        else $error("byte write did not take one step");

    a_half_two_steps: assert property (@(posedge clk_i) disable iff (rst_i)
        data_acc && acc_len == LEN_HALF |=> s_run2)
        else $error("halfword write did not take two steps");

    a_word_four_steps: assert property (@(posedge clk_i) disable iff (rst_i)
        data_acc && acc_len == LEN_WORD |=> s_run4)
        else $error("word write did not take four steps");

    a_hold_off_bus: assert property (@(posedge clk_i) disable iff (rst_i)
        st_reg == ST_RUN |=> !wb_ack_o)
        else $error("access answered while byte steps pending");

    a_lsb_first: assert property (@(posedge clk_i) disable iff (rst_i)
        data_acc && acc_len == LEN_WORD |=> sh_reg[7:0] == $past(wb_dat_i[7:0]))
        else $error("first byte step is not the low byte");

    a_seed_loads: assert property (@(posedge clk_i) disable iff (rst_i)
        acc && wb_we_i && wb_adr_i == OFF_SEED && !w16 |=> crc_reg == $past(wb_dat_i))
        else $error("seed write did not load the checksum");

    a_ccitt_poly: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg.psel == PSEL_CCITT && st_reg == ST_RUN && crc_reg == 32'h0
        && in_byte == 8'h01 |=> crc_reg == 32'h0000_1021)
        else $error("ccitt step wrong");

    a_crc16_poly: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg.psel == PSEL_CRC16 && st_reg == ST_RUN && crc_reg == 32'h0
        && in_byte == 8'h01 |=> crc_reg == 32'h0000_8005)
        else $error("crc-16 step wrong");

    a_crc32_poly: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg.psel == PSEL_CRC32 && st_reg == ST_RUN && crc_reg == 32'h0
        && in_byte == 8'h01 |=> crc_reg == 32'h04c1_1db7)
        else $error("crc-32 step wrong");

    a_prog_poly: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg.psel == PSEL_PROG && st_reg == ST_RUN && crc_reg == 32'h0
        && in_byte == 8'h01 |=> crc_reg == $past(poly_reg))
        else $error("programmed polynomial not used");

    a_in_cmpl: assert property (@(posedge clk_i) disable iff (rst_i)
        st_reg == ST_RUN && mode_reg.cmpl_in && !mode_reg.rev_in |-> in_byte == ~sh_reg[7:0])
        else $error("input complement not applied");

    a_sum_cmpl: assert property (@(posedge clk_i) disable iff (rst_i)
        acc && !wb_we_i && wb_adr_i == OFF_SUM && mode_reg.cmpl_sum && !mode_reg.rev_sum
        && !w16 |=> wb_dat_o == ~$past(crc_reg))
        else $error("sum complement not applied");

    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");

    a_poly_select: assert property (@(posedge clk_i) disable iff (rst_i)
        w16 |-> mode_reg.psel == PSEL_CCITT || mode_reg.psel == PSEL_CRC16)
        else $error("width does not follow polynomial select");

endmodule // crcen_top

`default_nettype wire

//--- shared/crcen_pkg.sv
// package with register map, field layout, reset values and types of the crc engine
package crcen_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte offsets on the wishbone slave
    localparam int unsigned ADR_W    = 8;
    localparam logic [7:0]  OFF_MODE = 8'h00;
    localparam logic [7:0]  OFF_SEED = 8'h04;
    localparam logic [7:0]  OFF_POLY = 8'h08;
    localparam logic [7:0]  OFF_DATA = 8'h0c;
    localparam logic [7:0]  OFF_SUM  = 8'h10;

    ////////////////////////////////////////////////////////////////////////////////
    // generator polynomials, top term implied
    localparam logic [31:0] POLY_CCITT = 32'h0000_1021;
    localparam logic [31:0] POLY_CRC16 = 32'h0000_8005;
    localparam logic [31:0] POLY_CRC32 = 32'h04c1_1db7;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [31:0] SEED_RST = 32'h0000_ffff;
    localparam logic [31:0] POLY_RST = 32'h04c1_1db7;
    localparam logic [15:0] MASK16   = 16'hffff;

    ////////////////////////////////////////////////////////////////////////////////
    // byte lane enables that are accepted on the data register
    localparam logic [3:0] SEL_WORD = 4'hf;
    localparam logic [3:0] SEL_HI   = 4'hc;
    localparam logic [3:0] SEL_LO   = 4'h3;
    localparam logic [3:0] SEL_B0   = 4'h1;
    localparam logic [3:0] SEL_B1   = 4'h2;
    localparam logic [3:0] SEL_B2   = 4'h4;
    localparam logic [3:0] SEL_B3   = 4'h8;

    localparam logic [2:0] LEN_BYTE = 3'h1;
    localparam logic [2:0] LEN_HALF = 3'h2;
    localparam logic [2:0] LEN_WORD = 3'h4;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        PSEL_CCITT = 2'h0,
        PSEL_CRC16 = 2'h1,
        PSEL_CRC32 = 2'h2,
        PSEL_PROG  = 2'h3
    } crcen_psel_t;

    // mode register, bits 5..0
    typedef struct packed {
        logic        cmpl_sum;
        logic        rev_sum;
        logic        cmpl_in;
        logic        rev_in;
        crcen_psel_t psel;
    } crcen_mode_t;

    localparam crcen_mode_t MODE_RST = '{1'b0, 1'b0, 1'b0, 1'b0, PSEL_CCITT};

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } crcen_state_t;

endpackage
